// >>> rtl/perf_event_select_decode.sv
// Event-select decoder and counter for one performance-monitoring counter.
`timescale 1ns/1ps

module perf_event_select_decode
  import perf_event_select_pkg::*;
#(
  parameter int unsigned CNT_W = COUNT_W,
  parameter int unsigned OCC_WIDTH = OCC_W
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Selection from software.
  input wire logic count_enable_in,
  input wire logic counter_clear_in,
  input wire logic [7:0] event_code_in,
  input wire logic [7:0] unit_mask_in,
  input wire logic invert_compare_in,
  input wire logic [7:0] counter_mask_in,
  // Retired load occurrences.
  input wire logic load_retire_in,
  input wire logic load_l1_miss_in,
  input wire logic load_fill_buffer_hit_in,
  input wire logic load_tlb_miss_in,
  input wire logic load_fault_in,
  input wire logic load_cacheable_in,
  input wire logic load_sw_prefetch_in,
  // Instruction class of the instruction issued this cycle.
  input wire logic float_insn_in,
  input wire logic packed_int_insn_in,
  // Decode occurrences per cycle.
  input wire logic [OCC_WIDTH-1:0] decoded_insts_in,
  input wire logic [OCC_WIDTH-1:0] decoded_uops_in,
  input wire logic [OCC_WIDTH-1:0] sequencer_uops_in,
  input wire logic [OCC_WIDTH-1:0] stack_folding_in,
  input wire logic stack_sync_in,
  // Allocation stall cycle.
  input wire logic flag_stall_in,
  // Results.
  output logic [CNT_W-1:0] counter_out,
  output logic event_match_out,
  output logic increment_out
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    insn_class_t last_class;
    logic match;
    logic incr;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic supported;
  logic [OCC_WIDTH-1:0] raw_amount;
  logic [OCC_WIDTH-1:0] step;
  logic to_float;
  logic to_packed_int;
  logic [OCC_WIDTH-1:0] occ_one;
  logic [7:0] amount_wide;
  logic fill_hit_load;
  logic tlb_miss_load;

  assign occ_one = OCC_WIDTH'(1'b1);
  // The threshold compares against the full counter mask, so the amount is widened to match it.
  assign amount_wide = 8'(raw_amount);

  // Qualifies a retiring load for the two load selections.
  always_comb begin
    fill_hit_load = load_retire_in && load_l1_miss_in && load_fill_buffer_hit_in;
    tlb_miss_load = load_retire_in && load_tlb_miss_in;
    if (load_fault_in) begin
      tlb_miss_load = 1'b0;
    end
    if (!load_cacheable_in || load_sw_prefetch_in) begin
      tlb_miss_load = 1'b0;
    end
  end

  // Transitions seen against the class of the last classed instruction.
  always_comb begin
    to_float = float_insn_in && (state_q.last_class == CLASS_PACKED_INT);
    to_packed_int = packed_int_insn_in && (state_q.last_class == CLASS_FLOAT);
  end

  // Selects the occurrence amount for the programmed code and mask.
  always_comb begin
    supported = 1'b0;
    raw_amount = '0;
    case (event_code_in)
      EVT_LOAD_RETIRED: begin
        case (unit_mask_in)
          UM_FILL_BUFFER_HIT: begin
            supported = 1'b1;
            raw_amount = OCC_WIDTH'(fill_hit_load);
          end
          UM_TLB_MISS: begin
            supported = 1'b1;
            raw_amount = OCC_WIDTH'(tlb_miss_load);
          end
          default: begin
            supported = 1'b0;
          end
        endcase
      end
      EVT_STATE_TRANS: begin
        case (unit_mask_in)
          UM_TO_FLOAT: begin
            supported = 1'b1;
            raw_amount = OCC_WIDTH'(to_float);
          end
          UM_TO_PACKED_INT: begin
            supported = 1'b1;
            raw_amount = OCC_WIDTH'(to_packed_int);
          end
          UM_ANY_DIRECTION: begin
            supported = 1'b1;
            raw_amount = OCC_WIDTH'(to_float || to_packed_int);
          end
          default: begin
            supported = 1'b0;
          end
        endcase
      end
      EVT_DECODED_INSN: begin
        case (unit_mask_in)
          UM_DECODED: begin
            supported = 1'b1;
            raw_amount = decoded_insts_in;
          end
          default: begin
            supported = 1'b0;
          end
        endcase
      end
      EVT_UOP_DECODE: begin
        case (unit_mask_in)
          UM_STALL_CYCLES: begin
            supported = (invert_compare_in == STALL_INVERT) && (counter_mask_in == STALL_CMASK);
            raw_amount = decoded_uops_in;
          end
          UM_SEQUENCER_UOPS: begin
            supported = 1'b1;
            raw_amount = sequencer_uops_in;
          end
          UM_STACK_FOLDING: begin
            supported = 1'b1;
            raw_amount = stack_folding_in;
          end
          UM_STACK_SYNC: begin
            supported = 1'b1;
            raw_amount = OCC_WIDTH'(stack_sync_in);
          end
          default: begin
            supported = 1'b0;
          end
        endcase
      end
      EVT_ALLOC_STALL: begin
        case (unit_mask_in)
          UM_FLAG_STALL: begin
            supported = 1'b1;
            raw_amount = OCC_WIDTH'(flag_stall_in);
          end
          default: begin
            supported = 1'b0;
          end
        endcase
      end
      default: begin
        supported = 1'b0;
      end
    endcase
  end

  // Applies the counter mask threshold and the invert flag.
  // A zero counter mask adds the raw amount and ignores the invert flag.
  always_comb begin
    step = raw_amount;
    if (counter_mask_in != 8'h00) begin
      if (invert_compare_in) begin
        step = (amount_wide < counter_mask_in) ? occ_one : '0;
      end else begin
        step = (amount_wide >= counter_mask_in) ? occ_one : '0;
      end
    end
  end

  // Next state of the whole block.
  always_comb begin
    state_d = state_q;
    state_d.match = supported;
    state_d.incr = 1'b0;
    // The class tracker follows every instruction, even while counting is off, so no transition is missed.
    if (float_insn_in && !packed_int_insn_in) begin
      state_d.last_class = CLASS_FLOAT;
    end else if (packed_int_insn_in && !float_insn_in) begin
      state_d.last_class = CLASS_PACKED_INT;
    end
    // A clear in the same cycle as an occurrence wins, so software reads zero afterwards.
    if (counter_clear_in) begin
      state_d.count = CNT_W'(COUNT_RESET);
    end else if (count_enable_in && supported && (step != '0)) begin
      state_d.count = state_q.count + CNT_W'(step);
      state_d.incr = 1'b1;
    end
  end

  // One register holds the whole state, so reset and update cannot drift apart.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= '{count: CNT_W'(COUNT_RESET), last_class: CLASS_NONE, match: 1'b0, incr: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign counter_out = state_q.count;
  assign event_match_out = state_q.match;
  assign increment_out = state_q.incr;

endmodule : perf_event_select_decode

// >>> rtl/perf_event_select_pkg.sv
// Constants and types for the performance event-select decoder.
package perf_event_select_pkg;

  localparam int unsigned COUNT_W = 48;
  localparam int unsigned OCC_W = 3;

  // Event codes.
  localparam logic [7:0] EVT_LOAD_RETIRED = 8'hcb;
  localparam logic [7:0] EVT_STATE_TRANS = 8'hcc;
  localparam logic [7:0] EVT_DECODED_INSN = 8'hd0;
  localparam logic [7:0] EVT_UOP_DECODE = 8'hd1;
  localparam logic [7:0] EVT_ALLOC_STALL = 8'hd2;

  // Unit masks.
  localparam logic [7:0] UM_FILL_BUFFER_HIT = 8'h40;
  localparam logic [7:0] UM_TLB_MISS = 8'h80;
  localparam logic [7:0] UM_TO_FLOAT = 8'h01;
  localparam logic [7:0] UM_TO_PACKED_INT = 8'h02;
  localparam logic [7:0] UM_ANY_DIRECTION = 8'h03;
  localparam logic [7:0] UM_DECODED = 8'h01;
  localparam logic [7:0] UM_STALL_CYCLES = 8'h01;
  localparam logic [7:0] UM_SEQUENCER_UOPS = 8'h02;
  localparam logic [7:0] UM_STACK_FOLDING = 8'h04;
  localparam logic [7:0] UM_STACK_SYNC = 8'h08;
  localparam logic [7:0] UM_FLAG_STALL = 8'h01;

  // Compare settings demanded by the decoder stall selection.
  localparam logic STALL_INVERT = 1'b1;
  localparam logic [7:0] STALL_CMASK = 8'h01;

  // Reset values.
  localparam logic [COUNT_W-1:0] COUNT_RESET = '0;

  typedef enum logic [1:0] {
    CLASS_NONE,
    CLASS_FLOAT,
    CLASS_PACKED_INT
  } insn_class_t;

endpackage : perf_event_select_pkg

// >>> testbench/perf_event_select_monitor.sv
// Checker of counting relations at the decoder ports.
`timescale 1ns/1ps
module perf_event_select_monitor
  import perf_event_select_pkg::*;
#(parameter int unsigned CNT_W = COUNT_W, parameter int unsigned OCC_WIDTH = OCC_W) (
  input wire logic ref_clk_in, rst_in, count_enable_in, counter_clear_in, invert_compare_in, flag_stall_in,
  input wire logic load_retire_in, load_l1_miss_in, load_fill_buffer_hit_in, load_fault_in, load_cacheable_in,
  input wire logic load_sw_prefetch_in, increment_out,
  input wire logic [7:0] event_code_in, unit_mask_in, counter_mask_in,
  input wire logic [OCC_WIDTH-1:0] decoded_insts_in, decoded_uops_in,
  input wire logic [CNT_W-1:0] counter_out
);
  wire logic go = count_enable_in && !counter_clear_in;
  wire logic raw = go && counter_mask_in == 8'h00;
  wire logic [15:0] ev = {event_code_in, unit_mask_in};
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  fill_hit_a:
    assert property (raw && ev == 16'hcb40 && load_retire_in && load_l1_miss_in && load_fill_buffer_hit_in
      |=> counter_out == $past(counter_out) + 1) else $error("fill hit lost");
  tlb_fault_a:
    assert property (raw && ev == 16'hcb80 && load_fault_in |=> $stable(counter_out)) else $error("fault counted");
  tlb_kind_a:
    assert property (raw && ev == 16'hcb80 && (load_sw_prefetch_in || !load_cacheable_in)
      |=> $stable(counter_out)) else $error("load counted");
  insn_sum_a:
    assert property (raw && ev == 16'hd001 |=> counter_out == $past(counter_out) + $past(decoded_insts_in))
      else $error("sum wrong");
  idle_decode_a:
    assert property (go && ev == 16'hd101 && invert_compare_in && counter_mask_in == 8'h01 && decoded_uops_in == '0
      |=> counter_out == $past(counter_out) + 1) else $error("stall lost");
  flag_stall_a:
    assert property (raw && ev == 16'hd201 && flag_stall_in |=> increment_out ##0 counter_out == $past(counter_out) + 1)
      else $error("flag stall lost");
  bad_code_a:
    assert property (!counter_clear_in && !(event_code_in inside {8'hcb, 8'hcc, 8'hd0, 8'hd1, 8'hd2})
      |=> !increment_out && $stable(counter_out)) else $error("bad code counted");
  disabled_a:
    assert property (!count_enable_in && !counter_clear_in |=> !increment_out && $stable(counter_out))
      else $error("disabled moved");
endmodule : perf_event_select_monitor

bind perf_event_select_decode perf_event_select_monitor #(.CNT_W(CNT_W), .OCC_WIDTH(OCC_WIDTH)) mon_u (.*);

// >>> testbench/pipe_event_src.sv
// Model of the pipeline sources that raise per-cycle occurrences.
`timescale 1ns/1ps
module pipe_event_src (
  input wire logic ref_clk_in,
  output logic [22:0] occ_out
);
  initial occ_out = 23'h000000;
  task put(input logic [22:0] v);
    @(posedge ref_clk_in);
    #1 occ_out = v;
  endtask : put
endmodule : pipe_event_src

// >>> testbench/tb_top.sv
// Self-checking testbench for the event-select decoder.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, count_enable_in = 1'b0, counter_clear_in = 1'b0, invert_compare_in = 1'b0;
  logic [7:0] event_code_in = 8'h00, unit_mask_in = 8'h00, counter_mask_in = 8'h00;
  logic load_retire_in, load_l1_miss_in, load_fill_buffer_hit_in, load_tlb_miss_in, load_fault_in, load_cacheable_in;
  logic load_sw_prefetch_in, float_insn_in, packed_int_insn_in, stack_sync_in, flag_stall_in;
  logic event_match_out, increment_out;
  logic [2:0] decoded_insts_in, decoded_uops_in, sequencer_uops_in, stack_folding_in;
  logic [22:0] occ;
  logic [47:0] counter_out;
  int n_errors = 0;
  int checks_done = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  assign {flag_stall_in, stack_sync_in, stack_folding_in, sequencer_uops_in, decoded_uops_in, decoded_insts_in,
    packed_int_insn_in, float_insn_in, load_sw_prefetch_in, load_cacheable_in, load_fault_in, load_tlb_miss_in,
    load_fill_buffer_hit_in, load_l1_miss_in, load_retire_in} = occ;
  pipe_event_src src_u (.ref_clk_in(ref_clk_in), .occ_out(occ));
  perf_event_select_decode dut_u (.*);
  task chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag got %b want %b", $time, got, exp);
    end
  endtask : chk_bit
  task sel(input logic [15:0] ev, input logic invert = 1'b0, input logic [7:0] cm = 8'h00);
    {event_code_in, unit_mask_in} = ev;
    invert_compare_in = invert;
    counter_mask_in = cm;
  endtask : sel
  task step(input logic [22:0] v, input logic en, input int d);
    logic [47:0] c0;
    c0 = counter_out;
    src_u.put(v);
    count_enable_in = en;
    src_u.put(23'h000000);
    count_enable_in = 1'b0;
    chk(counter_out, c0 + d);
    chk_bit(increment_out, d != 0);
  endtask : step
  task t_loads;
    sel(16'hcb40);
    step(23'h000007, 1'b1, 1);
    step(23'h000003, 1'b1, 0);
    sel(16'hcb80);
    step(23'h000029, 1'b1, 1);
    step(23'h000039, 1'b1, 0);
    step(23'h000009, 1'b1, 0);
    step(23'h000069, 1'b1, 0);
  endtask : t_loads
  task t_trans;
    for (int i = 0; i < 3; i++) begin
      sel({8'hcc, 8'(i + 1)});
      step(23'h000100, 1'b1, 0);
      step(23'h000080, 1'b1, i != 1);
      step(23'h000080, 1'b1, 0);
      step(23'h000100, 1'b1, i != 0);
    end
  endtask : t_trans
  task t_decode;
    sel(16'hd001);
    step(23'h000a00, 1'b1, 5);
    sel(16'hd001, 1'b0, 8'h02);
    step(23'h000a00, 1'b1, 1);
    step(23'h000200, 1'b1, 0);
    sel(16'hd101, 1'b1, 8'h01);
    step(23'h000000, 1'b1, 1);
    step(23'h003000, 1'b1, 0);
    sel(16'hd101, 1'b0, 8'h01);
    step(23'h003000, 1'b1, 0);
    sel(16'hd102);
    step(23'h030000, 1'b1, 6);
    sel(16'hd104);
    step(23'h0c0000, 1'b1, 3);
    sel(16'hd108);
    step(23'h200000, 1'b1, 1);
    sel(16'hd201);
    step(23'h400000, 1'b1, 1);
  endtask : t_decode
  task t_refuse;
    sel(16'hcb20);
    step(23'h000007, 1'b1, 0);
    chk_bit(event_match_out, 1'b0);
    sel(16'hcd40);
    step(23'h000007, 1'b1, 0);
    sel(16'hcb40);
    step(23'h000007, 1'b0, 0);
    chk_bit(event_match_out, 1'b1);
    src_u.put(23'h000007);
    count_enable_in = 1'b1;
    counter_clear_in = 1'b1;
    src_u.put(23'h000000);
    count_enable_in = 1'b0;
    counter_clear_in = 1'b0;
    chk(counter_out, 48'h0);
    chk_bit(increment_out, 1'b0);
  endtask : t_refuse
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge ref_clk_in);
    #1 rst_in = 1'b0;
    chk(counter_out, 48'h0);
    chk_bit(event_match_out, 1'b0);
    chk_bit(increment_out, 1'b0);
    t_loads;
    t_trans;
    t_decode;
    t_refuse;
    end_of_test;
  end
  initial begin
    #20000;
    n_errors++;
    end_of_test;
  end
endmodule : tb_top
